// file: slcr_host.sv
// host model driving the serial port's register strobes
`timescale 1ns/10ps
module slcr_host (
	input  wire logic           clk,
	output logic [5:0]          reg_addr,
	output logic                reg_wr,
	output logic                reg_rd,
	output slcr_pkg::slcr_word_t reg_wdata
);
	// idle values chosen so nothing is mistaken for an access
	initial begin
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 24'h000000;
	end

	// one strobe, taken at the next rising edge; stale data inverted after
	task automatic access(input logic wr, input logic [5:0] a,
		input slcr_pkg::slcr_word_t d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = wr;
		reg_rd = !wr;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~d;
		reg_addr = ~a;
	endtask : access
endmodule : slcr_host

// file: slcr_map.svh
// register offsets, field masks, reset values and start-up codes
`ifndef SLCR_MAP_SVH
`define SLCR_MAP_SVH

// register offsets on the serial register port
`define SLCR_OFS_BUCK1_VOLTAGE        6'h18
`define SLCR_OFS_BUCK2_BUCK3_VOLTAGE  6'h19
`define SLCR_OFS_BUCK4_VOLTAGE        6'h1a
`define SLCR_OFS_BUCK5_VOLTAGE        6'h1b
`define SLCR_OFS_BUCK1_BUCK2_MODE     6'h1c
`define SLCR_OFS_BUCK3_TO_BUCK5_MODE  6'h1d
`define SLCR_OFS_LDO_VOLTAGE_SETTING  6'h1e
`define SLCR_OFS_BOOST_CONTROL        6'h1f

// the bank occupies one aligned group of eight offsets
`define SLCR_BANK_BASE_HI             3'h3

// writable bits of each register
`define SLCR_WMASK_R24                24'h000fff
`define SLCR_WMASK_R25                24'h7dffff
`define SLCR_WMASK_R26                24'hffffff
`define SLCR_WMASK_R27                24'h007c1f
`define SLCR_WMASK_R28                24'hffc0ff
`define SLCR_WMASK_R29                24'hffffff
`define SLCR_WMASK_R30                24'h001ff7
`define SLCR_WMASK_R31                24'h00007f

// bits returned to defaults by the system reset
`define SLCR_SMASK_R26                24'hff0000
`define SLCR_SMASK_R28                24'hf3c0cf
`define SLCR_SMASK_R29                24'h3cf3cf
`define SLCR_SMASK_R30                24'h001ff7
`define SLCR_SMASK_R31                24'h00007c

// system reset values of those bits
`define SLCR_SVAL_R26                 24'h000000
`define SLCR_SVAL_R28                 24'h520048
`define SLCR_SVAL_R29                 24'h208208
`define SLCR_SVAL_R30                 24'h000000
`define SLCR_SVAL_R31                 24'h000048

// memory-hold and user-off bits, cleared by the off reset only
`define SLCR_OMASK_R28                24'h0c0030
`define SLCR_OMASK_R29                24'hc30c30

// bits that the start-up sequencer loads
`define SLCR_LMASK_R24                24'h000fff
`define SLCR_LMASK_R25                24'h7dffff
`define SLCR_LMASK_R26                24'h00ffff
`define SLCR_LMASK_R27                24'h007c1f
`define SLCR_LMASK_R28                24'h03c00f
`define SLCR_LMASK_R29                24'h3cf3cf
`define SLCR_LMASK_R31                24'h000003

// mode field positions
`define SLCR_POS_B1A_MODE             0
`define SLCR_POS_B2_MODE              14
`define SLCR_POS_B3_MODE              0
`define SLCR_POS_B4A_MODE             6
`define SLCR_POS_B4B_MODE             12
`define SLCR_POS_B5_MODE              18

// pll control bits in the buck1/buck2 mode register
`define SLCR_POS_PLL_EN               22
`define SLCR_POS_PLL_MULT             23

// mode codes chosen by the start-up sequencer
`define SLCR_MODE_AUTO_PULSE_SKIP     4'h8
`define SLCR_MODE_OFF                 4'h0

`endif

// file: slcr_pkg.sv
// shared types of the regulator control register bank
package slcr_pkg;
	typedef logic [23:0] slcr_word_t;
	typedef logic [2:0]  slcr_idx_t;
	typedef logic [3:0]  slcr_mode_t;
endpackage : slcr_pkg

// file: slcr_regs.sv
// regulator control register bank: buck, ldo, boost and pll settings
`timescale 1ns/10ps
`include "slcr_map.svh"

// How it works
// RQ1: the buck1 voltage register holds a normal code in bits 0-5, a standby code in bits 6-11, bits 12-23 reserved.
// RQ2: the buck2/buck3 register holds buck2 codes in 0-5 and 6-11, buck3 codes in 12-16 and 18-22, bits 17 and 23 read zero.
// RQ3: the buck4 register holds 4A normal, standby and high fields in 0-11 and 4B fields in 12-23, bits 16-23 reset by system reset.
// RQ4: the buck5 register holds a normal code in bits 0-4 and a standby code in bits 10-14, all else unused.
// RQ5: buck1 and buck2 mode fields sit at bits 0-3 and 14-17 and reset to a code with only the top bit set, bits 8-13 unused.
// RQ6: every buck has a memory-hold and a user-off bit that default zero and are cleared only by the off reset.
// RQ7: dvs ramp speed fields for buck1 and buck2 sit at bits 6-7 and 20-21 and reset to binary 01.
// RQ8: bit 22 enables the pll and resets to one, bit 23 selects the pll multiplier and resets to zero.
// RQ9: the start-up sequencer reloads mode fields from the straps, an enabled buck getting auto pulse skip.
// RQ10: the buck3-5 mode register holds mode fields at 0, 6, 12 and 18, each followed by its hold and off bits.
// RQ11: the ldo register holds the five ldo codes at 0-2, 4-5, 6-8, 9-10 and 11-12, all reset by system reset.
// RQ12: the boost register holds a setting in 0-1, a mode in 2-3 and a standby mode in 5-6 both resetting to 10, and a spare bit 4.
// RQ13: unused and reserved bits read zero and ignore writes.
// RQ14: fields with no reset source keep their value through both resets and are loaded from the straps.
module slcr_regs (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic                    system_reset_n,
	input  wire logic                    off_reset_n,
	input  wire logic [5:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire slcr_pkg::slcr_word_t    reg_wdata,
	output slcr_pkg::slcr_word_t         reg_rdata,
	output logic                         reg_rvalid,
	input  wire logic                    strap_load,
	input  wire logic [5:0]              power_up_strap_en,
	input  wire slcr_pkg::slcr_word_t    strap_buck1_voltage,
	input  wire slcr_pkg::slcr_word_t    strap_buck2_buck3_voltage,
	input  wire slcr_pkg::slcr_word_t    strap_buck4_voltage,
	input  wire slcr_pkg::slcr_word_t    strap_buck5_voltage,
	input  wire logic [1:0]              strap_boost_setting,
	output slcr_pkg::slcr_word_t         buck1_voltage,
	output slcr_pkg::slcr_word_t         buck2_buck3_voltage,
	output slcr_pkg::slcr_word_t         buck4_voltage,
	output slcr_pkg::slcr_word_t         buck5_voltage,
	output slcr_pkg::slcr_word_t         buck1_buck2_mode,
	output slcr_pkg::slcr_word_t         buck3_to_buck5_mode,
	output slcr_pkg::slcr_word_t         ldo_voltage_setting,
	output slcr_pkg::slcr_word_t         boost_control,
	output logic                         pll_enable_bit,
	output logic                         pll_multiplier_select
);
	// per-register constant tables
	function automatic slcr_pkg::slcr_word_t wmask(input int i);
		case (i)
			0: wmask = `SLCR_WMASK_R24;
			1: wmask = `SLCR_WMASK_R25;
			2: wmask = `SLCR_WMASK_R26;
			3: wmask = `SLCR_WMASK_R27;
			4: wmask = `SLCR_WMASK_R28;
			5: wmask = `SLCR_WMASK_R29;
			6: wmask = `SLCR_WMASK_R30;
			default: wmask = `SLCR_WMASK_R31;
		endcase
	endfunction : wmask

	function automatic slcr_pkg::slcr_word_t smask(input int i);
		case (i)
			2: smask = `SLCR_SMASK_R26;
			4: smask = `SLCR_SMASK_R28;
			5: smask = `SLCR_SMASK_R29;
			6: smask = `SLCR_SMASK_R30;
			7: smask = `SLCR_SMASK_R31;
			default: smask = 24'h000000;
		endcase
	endfunction : smask

	function automatic slcr_pkg::slcr_word_t sval(input int i);
		case (i)
			2: sval = `SLCR_SVAL_R26;
			4: sval = `SLCR_SVAL_R28;
			5: sval = `SLCR_SVAL_R29;
			6: sval = `SLCR_SVAL_R30;
			7: sval = `SLCR_SVAL_R31;
			default: sval = 24'h000000;
		endcase
	endfunction : sval

	function automatic slcr_pkg::slcr_word_t omask(input int i);
		case (i)
			4: omask = `SLCR_OMASK_R28;
			5: omask = `SLCR_OMASK_R29;
			default: omask = 24'h000000;
		endcase
	endfunction : omask

	function automatic slcr_pkg::slcr_word_t lmask(input int i);
		case (i)
			0: lmask = `SLCR_LMASK_R24;
			1: lmask = `SLCR_LMASK_R25;
			2: lmask = `SLCR_LMASK_R26;
			3: lmask = `SLCR_LMASK_R27;
			4: lmask = `SLCR_LMASK_R28;
			5: lmask = `SLCR_LMASK_R29;
			7: lmask = `SLCR_LMASK_R31;
			default: lmask = 24'h000000;
		endcase
	endfunction : lmask

	// replace the masked bits of old with those of new
	function automatic slcr_pkg::slcr_word_t merge(
		input slcr_pkg::slcr_word_t old_v,
		input slcr_pkg::slcr_word_t new_v,
		input slcr_pkg::slcr_word_t m
	);
		merge = (old_v & ~m) | (new_v & m);
	endfunction : merge

	// mode code that the start-up sequencer gives one buck
	function automatic slcr_pkg::slcr_mode_t strap_mode(input logic en);
		strap_mode = en ? `SLCR_MODE_AUTO_PULSE_SKIP : `SLCR_MODE_OFF;
	endfunction : strap_mode

	slcr_pkg::slcr_word_t r_q [0:7];
	slcr_pkg::slcr_word_t r_d [0:7];
	slcr_pkg::slcr_word_t strap_val [0:7];
	slcr_pkg::slcr_word_t rdata_q;
	logic                 rvalid_q;
	logic [1:0]           rst_sync;
	wire                  sys_rst_act;
	wire                  off_rst_act;
	wire                  bank_hit;
	slcr_pkg::slcr_idx_t  idx;
	wire                  wr_hit;
	slcr_pkg::slcr_word_t rd_word;

	// reset pins come from outside the clock domain
	slcr_sync2 #(
		.W (2)
	) u_rst_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({off_reset_n, system_reset_n}),
		.sync_out (rst_sync)
	);

	assign sys_rst_act = ~rst_sync[0];
	assign off_rst_act = ~rst_sync[1];

	// address decode: only the eight bank offsets take writes; reads elsewhere still answer, with zero data
	assign bank_hit = (reg_addr[5:3] == `SLCR_BANK_BASE_HI);
	assign idx      = reg_addr[2:0];
	assign wr_hit   = reg_wr & bank_hit;
	assign rd_word  = bank_hit ? r_q[idx] : 24'h000000; // see RQ13

	// start-up values; mode fields follow the buck enable straps
	assign strap_val[0] = strap_buck1_voltage;                  // see RQ14
	assign strap_val[1] = strap_buck2_buck3_voltage;            // see RQ14
	assign strap_val[2] = strap_buck4_voltage;                  // see RQ14
	assign strap_val[3] = strap_buck5_voltage;                  // see RQ14
	assign strap_val[4] = {6'h00, strap_mode(power_up_strap_en[1]),
		10'h000, strap_mode(power_up_strap_en[0])};             // see RQ9
	assign strap_val[5] = {2'h0, strap_mode(power_up_strap_en[5]),
		2'h0, strap_mode(power_up_strap_en[4]),
		2'h0, strap_mode(power_up_strap_en[3]),
		2'h0, strap_mode(power_up_strap_en[2])};                // see RQ9
	assign strap_val[6] = 24'h000000;
	assign strap_val[7] = {22'h000000, strap_boost_setting};    // see RQ14

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_reg
			localparam slcr_pkg::slcr_word_t WM = wmask(gi);
			localparam slcr_pkg::slcr_word_t SM = smask(gi);
			localparam slcr_pkg::slcr_word_t SV = sval(gi);
			localparam slcr_pkg::slcr_word_t OM = omask(gi);
			localparam slcr_pkg::slcr_word_t LM = lmask(gi);
			slcr_pkg::slcr_word_t after_wr;
			slcr_pkg::slcr_word_t after_ld;
			slcr_pkg::slcr_word_t after_sr;

			// priority: off reset, then system reset, then strap load, then write
			assign after_wr = (wr_hit && idx == gi) ?
				merge(r_q[gi], reg_wdata, WM) : r_q[gi];        // see RQ13
			assign after_ld = strap_load ?
				merge(after_wr, strap_val[gi], LM) : after_wr;  // see RQ9
			assign after_sr = sys_rst_act ?
				merge(after_ld, SV, SM) : after_ld;  // see RQ3, RQ5, RQ7, RQ8
			assign r_d[gi]  = off_rst_act ? (after_sr & ~OM) : after_sr; // see RQ6

			// power-on: defaults where known, strap fields zero until loaded
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					r_q[gi] <= SV & SM;
				end else begin
					r_q[gi] <= r_d[gi] & WM; // see RQ13
				end
			end
		end
	endgenerate

	// read data registered one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q  <= 24'h000000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= reg_rd ? rd_word : rdata_q;
			rvalid_q <= reg_rd;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// register contents drive the regulators directly
	assign buck1_voltage         = r_q[0]; // see RQ1
	assign buck2_buck3_voltage   = r_q[1]; // see RQ2
	assign buck4_voltage         = r_q[2]; // see RQ3
	assign buck5_voltage         = r_q[3]; // see RQ4
	assign buck1_buck2_mode      = r_q[4]; // see RQ5, RQ7
	assign buck3_to_buck5_mode   = r_q[5]; // see RQ10
	assign ldo_voltage_setting   = r_q[6]; // see RQ11
	assign boost_control         = r_q[7]; // see RQ12
	assign pll_enable_bit        = r_q[4][`SLCR_POS_PLL_EN];   // see RQ8
	assign pll_multiplier_select = r_q[4][`SLCR_POS_PLL_MULT]; // see RQ8
endmodule : slcr_regs

// file: slcr_regs_assertions.sv
// timing and bit-layout checks on the regulator control register bank
`timescale 1ns/10ps
module slcr_regs_checker (
	input wire logic                 clk,
	input wire logic                 resetn,
	input wire logic                 strap_load,
	input wire logic [5:0]           reg_addr,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire slcr_pkg::slcr_word_t reg_wdata,
	input wire slcr_pkg::slcr_word_t reg_rdata,
	input wire logic                 reg_rvalid,
	input wire slcr_pkg::slcr_word_t buck1_voltage,
	input wire slcr_pkg::slcr_word_t buck5_voltage,
	input wire slcr_pkg::slcr_word_t buck1_buck2_mode,
	input wire slcr_pkg::slcr_word_t ldo_voltage_setting,
	input wire slcr_pkg::slcr_word_t boost_control,
	input wire logic                 pll_enable_bit,
	input wire logic                 pll_multiplier_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// access steps, named so the properties read as request then answer
	sequence s_wr18; reg_wr && reg_addr == 6'h18 && !strap_load; endsequence
	sequence s_rd1b; reg_rd && reg_addr == 6'h1b; endsequence
	sequence s_rd_out; reg_rd && reg_addr[5:3] != 3'h3; endsequence
	property p_rvalid; 1 |=> reg_rvalid == $past(reg_rd); endproperty
	property p_r24; buck1_voltage[23:12] == 12'h000; endproperty
	property p_r27; {buck5_voltage[23:15], buck5_voltage[9:5]} == 14'h0;
	endproperty
	property p_r28; buck1_buck2_mode[13:8] == 6'h00; endproperty
	property p_pll; {pll_multiplier_select, pll_enable_bit}
		== buck1_buck2_mode[23:22]; endproperty
	property p_r30; {ldo_voltage_setting[23:13], ldo_voltage_setting[3]}
		== 12'h000; endproperty
	property p_r31; boost_control[23:7] == 17'h0; endproperty
	property p_wr18; s_wr18 |=> buck1_voltage
		== ($past(reg_wdata) & 24'h000fff); endproperty
	property p_rd_old; s_rd1b |=> reg_rdata == $past(buck5_voltage);
	endproperty
	property p_rd_out; s_rd_out |=> reg_rdata == 24'h000000; endproperty
	a_rvalid: assert property (p_rvalid) else $error("rvalid not one cycle");
	a_r24: assert property (p_r24) else $error("reserved bits set");
	a_r27: assert property (p_r27) else $error("unused bits set");
	a_r28: assert property (p_r28) else $error("unused bits set");
	a_pll: assert property (p_pll) else $error("pll bits differ");
	a_r30: assert property (p_r30) else $error("unused bits set");
	a_r31: assert property (p_r31) else $error("unused bits set");
	a_wr18: assert property (p_wr18) else $error("write lost");
	a_rd_old: assert property (p_rd_old) else $error("bad read");
	a_rd_out: assert property (p_rd_out) else $error("bad read");
endmodule : slcr_regs_checker

bind slcr_regs slcr_regs_checker i_slcr_regs_checker (.*);

// file: slcr_sync2.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module slcr_sync2 #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second; reset value reads as asserted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : slcr_sync2

// file: tb.sv
// self-checking bench for the regulator control register bank
`timescale 1ns/10ps
module tb;
	typedef slcr_pkg::slcr_word_t w_t;
	localparam w_t WM[8] = '{24'h000fff, 24'h7dffff, 24'hffffff, 24'h007c1f,
		24'hffc0ff, 24'hffffff, 24'h001ff7, 24'h00007f};
	localparam w_t POR[8] = '{0, 0, 0, 0, 24'h520048, 24'h208208, 0, 24'h48};
	logic clk = 0, resetn = 0, sys_n = 1, off_n = 1, strap_load = 0;
	logic [5:0] reg_addr, en = 6'h00;
	logic reg_wr, reg_rd, reg_rvalid;
	logic [1:0] sb = 2'h2;
	w_t reg_wdata, reg_rdata, d, s1 = 24'h123456;
	w_t b23, b4, b35;
	w_t exp_q[$];
	int num_errors = 0, compares = 0, seed = 54811, rv;

	always #20 clk = ~clk;

	slcr_host i_slcr_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata));
	slcr_regs i_slcr_regs (.clk(clk), .resetn(resetn),
		.system_reset_n(sys_n), .off_reset_n(off_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.strap_load(strap_load), .power_up_strap_en(en),
		.strap_buck1_voltage(s1), .strap_buck2_buck3_voltage(~s1),
		.strap_buck4_voltage(s1), .strap_buck5_voltage(~s1),
		.strap_boost_setting(sb), .buck1_voltage(),
		.buck2_buck3_voltage(b23),
		.buck4_voltage(b4), .buck5_voltage(), .buck1_buck2_mode(),
		.buck3_to_buck5_mode(b35), .ldo_voltage_setting(), .boost_control(),
		.pll_enable_bit(), .pll_multiplier_select());

	task automatic check(input w_t seen, input w_t exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [5:0] a, input w_t exp);
		exp_q.push_back(exp);
		i_slcr_host.access(1'b0, a, 24'h000000);
	endtask : rd

	task automatic wr(input logic [5:0] a, input w_t v);
		i_slcr_host.access(1'b1, a, v);
	endtask : wr

	// hold a reset pin low long enough for the synchroniser, then settle
	task automatic pulse(input logic off);
		@(negedge clk);
		if (off) off_n = 1'b0; else sys_n = 1'b0;
		repeat (3) @(negedge clk);
		{sys_n, off_n} = 2'b11;
		repeat (4) @(negedge clk);
	endtask : pulse

	task automatic load(input logic [5:0] e);
		@(negedge clk);
		en = e;
		strap_load = 1'b1;
		@(negedge clk);
		strap_load = 1'b0;
	endtask : load

	// read answers are compared in the order they were requested
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1) begin
			// an answer nobody asked for is an error, unknown data or not
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("unexpected at %0t: got %h want %h", $time,
					reg_rdata, 24'h000000);
			end else begin
				check(reg_rdata, exp_q.pop_front());
			end
		end
	end

	task automatic give_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict

	// watchdog far beyond the roughly 130 cycles the sequence needs
	initial begin
		#200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 8; i++) rd(6'h18 + i, POR[i]);
		for (int i = 0; i < 8; i++) begin
			rv = $random(seed);
			d = rv[23:0];
			wr(6'h18 + i, d);
			rd(6'h18 + i, d & WM[i]);
		end
		wr(6'h10, 24'hffffff);
		rd(6'h10, 24'h000000);
		rd(6'h20, 24'h000000);
		foreach (WM[i]) wr(6'h18 + i, 24'hffffff);
		wr(6'h18, 24'habcdef);
		pulse(1'b0);
		rd(6'h1c, 24'h5e0078);
		rd(6'h1d, 24'he38e38);
		rd(6'h1a, 24'h00ffff);
		rd(6'h1e, 24'h000000);
		rd(6'h1f, 24'h00004b);
		rd(6'h18, 24'h000def);
		pulse(1'b1);
		rd(6'h1c, 24'h520048);
		rd(6'h1d, 24'h208208);
		rd(6'h18, 24'h000def);
		load(6'h00);
		rd(6'h1c, 24'h500040);
		rd(6'h1d, 24'h000000);
		rd(6'h18, s1 & 24'h000fff);
		load(6'h15);
		rd(6'h1c, 24'h500048);
		rd(6'h1d, 24'h008008);
		rd(6'h1f, 24'h00004a);
		repeat (3) @(negedge clk);
		// regulator-facing outputs must match the register contents
		check(b35, 24'h008008);
		check(b23, ~s1 & 24'h7dffff);
		check(b4, s1 & 24'h00ffff);
		give_verdict();
	end
endmodule : tb
